// ==== rtl/scis_consts.vh ====
`ifndef SCIS_CONSTS_VH
`define SCIS_CONSTS_VH
// Contract
// - special-only receive mode sets receive pending only for special-condition characters
// - special interrupt waits until offending character is read, then locks receive FIFO
// - error-reset command unlocks receive FIFO so DMA resumes
// - transmit interrupts gated by transmit enable bit D1 of interrupt control
// - transmit pending sets on full-to-empty buffer edge, never by enabling alone
// - synchronous flag load after CRC sets transmit pending, not buffer-empty status
// - transmit pending clears on buffer write or reset-transmit-pending command
// - external/status enable D0 of interrupt control gates external/status pending; latches still work without it
// - source with enable 0 shows live status (zero count reads zero) and never interrupts
// - any enabled change closes all latches; pending holds while latches closed
// - reset-external/status command reopens the latches
// - six sources: break/abort, underrun/END_OF_MESSAGE, CTS, DCD, sync/hunt, zero count
// - async break sets on null with framing error, clears on one, keeps null
// - SDLC abort sets on seven ones, clears on zero, forces hunt
// - both break/abort edges close latches, even while already pending
// - underrun/END_OF_MESSAGE closes latches only when set, at CRC load, send-abort or entry to async mode; reset silent
// - underrun/END_OF_MESSAGE also sets on send-abort, reads set in async mode
// - CTS/DCD latch on both edges; odd transition count keeps latches closed
// - zero count sets at zero, clears on reload, live, forced low when disabled
// - async and external-sync: sync/hunt mirrors sync pin, both edges close latches
// - crystal enabled in async mode forces sync/hunt zero, never closing latches
// - other sync modes: sync/hunt shows hunt, set by command, cleared on sync

// register byte offsets
`define SCIS_OFF_CMD 8'h00
`define SCIS_OFF_ICTL 8'h04
`define SCIS_OFF_MICTL 8'h08
`define SCIS_OFF_XEN 8'h0c
`define SCIS_OFF_MODE 8'h10
`define SCIS_OFF_STAT 8'h14
`define SCIS_OFF_PEND 8'h18
`define SCIS_OFF_RXST 8'h1c

// command bits
`define SCIS_CMD_RST_XS 0
`define SCIS_CMD_ERR_RST 1
`define SCIS_CMD_RST_TXP 2
`define SCIS_CMD_RST_EOM 3
`define SCIS_CMD_ABORT 4
`define SCIS_CMD_HUNT 5

// interrupt control fields
`define SCIS_IC_XS 0
`define SCIS_IC_TX 1
`define SCIS_IC_RXM 4:3
`define SCIS_RXM_SPECIAL 2'h3
`define SCIS_MIC_MIE 3

// mode bits
`define SCIS_MD_ASYNC 0
`define SCIS_MD_SDLC 1
`define SCIS_MD_EXTSYNC 2
`define SCIS_MD_XTAL 3

// source indices
`define SCIS_SRC_BRK 0
`define SCIS_SRC_EOM 1
`define SCIS_SRC_CTS 2
`define SCIS_SRC_DCD 3
`define SCIS_SRC_SYNC 4
`define SCIS_SRC_ZC 5
`define SCIS_RISE_ONLY 6'h22
`define SCIS_PARITY_SRC 6'h0c
`define SCIS_LIVE_SRC 6'h20

`define SCIS_RST_BYTE 8'h00
`define SCIS_PIN_IDLE 3'h1
`define SCIS_ABORT_ONES 3'h7
`endif

// ==== rtl/scis_top.v ====
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "scis_consts.vh"
module scis_top (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [31:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire wb_ack_o,
	input wire rx_pop_i,
	input wire rx_pop_special_i,
	input wire rx_char_i,
	input wire rx_char_null_i,
	input wire rx_frame_err_i,
	input wire rx_bit_valid_i,
	input wire rx_bit_i,
	input wire rx_sync_found_i,
	input wire tx_buf_full_i,
	input wire tx_buf_write_i,
	input wire tx_crc_load_i,
	input wire tx_flag_load_i,
	input wire baud_zero_i,
	input wire cts_n_i,
	input wire dcd_i,
	input wire sync_i,
	output wire rx_fifo_lock_o,
	output wire rx_keep_null_o,
	output wire rx_hunt_o,
	output wire int_req_o
);

	function hit;
		input [31:0] adr;
		input [7:0] off;
		begin
			hit = (adr[7:0] == off);
		end
	endfunction

	// bus slave
	reg ack_q;
	reg [31:0] dat_q;
	wire req = wb_cyc_i & wb_stb_i;
	// writes commit at the edge where the master samples ack
	wire wr_go = req & wb_we_i & ack_q & wb_sel_i[0];

	reg [7:0] ictl_q;
	reg [7:0] mictl_q;
	reg [5:0] xen_q;
	reg [3:0] mode_q;

	wire [5:0] cmd = (wr_go & hit(wb_adr_i, `SCIS_OFF_CMD)) ?
		wb_dat_i[5:0] : 6'h00;
	wire c_rst_xs = cmd[`SCIS_CMD_RST_XS];
	wire c_err_rst = cmd[`SCIS_CMD_ERR_RST];
	wire c_rst_txp = cmd[`SCIS_CMD_RST_TXP];
	wire c_rst_eom = cmd[`SCIS_CMD_RST_EOM];
	wire c_abort = cmd[`SCIS_CMD_ABORT];
	wire c_hunt = cmd[`SCIS_CMD_HUNT];

	wire m_async = mode_q[`SCIS_MD_ASYNC];
	wire m_sdlc = mode_q[`SCIS_MD_SDLC] & ~m_async;
	wire m_ext = mode_q[`SCIS_MD_EXTSYNC] & ~m_async;
	wire m_xtal = mode_q[`SCIS_MD_XTAL];

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ictl_q <= `SCIS_RST_BYTE;
			mictl_q <= `SCIS_RST_BYTE;
			xen_q <= 6'h00;
			mode_q <= 4'h0;
		end
		else if (wr_go)
		begin
			if (hit(wb_adr_i, `SCIS_OFF_ICTL))
				ictl_q <= wb_dat_i[7:0];
			if (hit(wb_adr_i, `SCIS_OFF_MICTL))
				mictl_q <= wb_dat_i[7:0];
			if (hit(wb_adr_i, `SCIS_OFF_XEN))
				xen_q <= wb_dat_i[5:0];
			if (hit(wb_adr_i, `SCIS_OFF_MODE))
				mode_q <= wb_dat_i[3:0];
		end
	end

	// pin synchronisers: three stages, a change counts when 2 and 3 agree
	wire [2:0] pin_raw = {sync_i, dcd_i, cts_n_i};
	// stages reset to the idle pin level, so no false edge follows reset
	localparam [2:0] pin_idle = `SCIS_PIN_IDLE;
	wire [2:0] pin_f;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_pin
			reg s1_q;
			reg s2_q;
			reg s3_q;
			reg f_q;
			always @(posedge clk_i)
			begin
				if (rst_i)
				begin
					s1_q <= pin_idle[gi];
					s2_q <= pin_idle[gi];
					s3_q <= pin_idle[gi];
					f_q <= pin_idle[gi];
				end
				else
				begin
					s1_q <= pin_raw[gi];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q)
						f_q <= s3_q;
				end
			end
			assign pin_f[gi] = f_q;
		end
	endgenerate

	// break / abort detection
	reg brk_q;
	reg [2:0] ones_q;
	reg keep_null_q;
	reg hunt_q;
	wire abort_hit = m_sdlc & rx_bit_valid_i & rx_bit_i &
		(ones_q == `SCIS_ABORT_ONES - 3'h1);
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			brk_q <= 1'b0;
			ones_q <= 3'h0;
			keep_null_q <= 1'b0;
		end
		else
		begin
			keep_null_q <= 1'b0;
			if (m_async)
			begin
				ones_q <= 3'h0;
				if (rx_char_i & rx_char_null_i & rx_frame_err_i)
					brk_q <= 1'b1;
				else if (brk_q & rx_bit_valid_i & rx_bit_i)
				begin
					brk_q <= 1'b0;
					// the receiver keeps exactly one null at break end
					keep_null_q <= 1'b1;
				end
			end
			else if (m_sdlc)
			begin
				if (rx_bit_valid_i)
				begin
					if (!rx_bit_i)
					begin
						ones_q <= 3'h0;
						brk_q <= 1'b0;
					end
					else if (ones_q != `SCIS_ABORT_ONES)
						ones_q <= ones_q + 3'h1;
				end
				if (abort_hit)
					brk_q <= 1'b1;
			end
			else
			begin
				// reads zero in the other synchronous modes
				ones_q <= 3'h0;
				brk_q <= 1'b0;
			end
		end
	end

	// hunt state for the synchronous modes
	always @(posedge clk_i)
	begin
		if (rst_i)
			hunt_q <= 1'b1;
		else if (c_hunt | abort_hit)
			hunt_q <= 1'b1;
		else if (rx_sync_found_i)
			hunt_q <= 1'b0;
	end

	// underrun / end of message
	reg eom_q;
	always @(posedge clk_i)
	begin
		if (rst_i)
			eom_q <= 1'b0;
		else if (tx_crc_load_i | c_abort)
			eom_q <= 1'b1;
		else if (c_rst_eom)
			eom_q <= 1'b0;
	end

	// live source vector
	wire eom_src = eom_q | m_async;
	wire cts_src = ~pin_f[0];
	wire dcd_src = pin_f[1];
	wire sync_src = m_async ? (pin_f[2] & ~m_xtal) :
		(m_ext ? pin_f[2] : hunt_q);
	wire zc_src = baud_zero_i & xen_q[`SCIS_SRC_ZC];
	wire [5:0] src = {zc_src, sync_src, dcd_src, cts_src, eom_src, brk_q};

	reg [5:0] src_q;
	reg [5:0] latch_q;
	reg closed_q;
	reg xs_ip_q;
	reg [5:0] latch_d;
	reg closed_d;

	wire [5:0] flip = src ^ src_q;
	// eom and zero count close only on their rising edge
	wire [5:0] ev = flip & (~`SCIS_RISE_ONLY | src);
	wire [5:0] chg = ev & xen_q;
	wire any_chg = |chg;
	wire brk_chg = chg[`SCIS_SRC_BRK];
	// odd transition count shows as latched value differing from live
	wire odd_keep = |(`SCIS_PARITY_SRC & xen_q & (latch_q ^ src));

	always @*
	begin
		latch_d = latch_q;
		closed_d = closed_q;
		if (!closed_q)
		begin
			if (any_chg)
			begin
				closed_d = 1'b1;
				latch_d = src;
			end
		end
		else if (c_rst_xs)
		begin
			if (any_chg)
				latch_d = src;
			else
				closed_d = odd_keep;
		end
		else if (brk_chg)
		begin
			// a break edge is recaptured while already pending
			latch_d[`SCIS_SRC_BRK] = src[`SCIS_SRC_BRK];
		end
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			src_q <= 6'h00;
			latch_q <= 6'h00;
			closed_q <= 1'b0;
			xs_ip_q <= 1'b0;
		end
		else
		begin
			src_q <= src;
			latch_q <= latch_d;
			closed_q <= closed_d;
			xs_ip_q <= closed_d & ictl_q[`SCIS_IC_XS];
		end
	end

	// status view: latched only where enabled, zero count always live
	wire [5:0] use_latch = xen_q & ~`SCIS_LIVE_SRC & {6{closed_q}};
	wire [5:0] view = (use_latch & latch_q) | (~use_latch & src);

	// transmit pending
	reg full_q;
	reg tx_ip_q;
	wire tx_empty_edge = full_q & ~tx_buf_full_i;
	wire tx_set = ictl_q[`SCIS_IC_TX] &
		(tx_empty_edge | (tx_flag_load_i & ~m_async));
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			full_q <= 1'b0;
			tx_ip_q <= 1'b0;
		end
		else
		begin
			full_q <= tx_buf_full_i;
			// set wins over a coincident clear
			if (tx_set)
				tx_ip_q <= 1'b1;
			else if (tx_buf_write_i | c_rst_txp)
				tx_ip_q <= 1'b0;
		end
	end

	// receive special-condition-only mode
	reg rx_ip_q;
	reg lock_q;
	wire rx_special_mode = (ictl_q[`SCIS_IC_RXM] == `SCIS_RXM_SPECIAL);
	// raised only after the offending character has left the fifo top
	wire rx_set = rx_special_mode & rx_pop_i & rx_pop_special_i;
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rx_ip_q <= 1'b0;
			lock_q <= 1'b0;
		end
		else if (rx_set)
		begin
			rx_ip_q <= 1'b1;
			lock_q <= 1'b1;
		end
		else if (c_err_rst)
		begin
			rx_ip_q <= 1'b0;
			lock_q <= 1'b0;
		end
	end

	// outputs
	reg int_q;
	always @(posedge clk_i)
	begin
		if (rst_i)
			int_q <= 1'b0;
		else
			int_q <= mictl_q[`SCIS_MIC_MIE] & (xs_ip_q | tx_ip_q | rx_ip_q);
	end

	// bus read mux; unmapped offsets read zero and are still acknowledged
	reg [31:0] rd_mux;
	always @*
	begin
		rd_mux = 32'h00000000;
		if (hit(wb_adr_i, `SCIS_OFF_ICTL))
			rd_mux[7:0] = ictl_q;
		if (hit(wb_adr_i, `SCIS_OFF_MICTL))
			rd_mux[7:0] = mictl_q;
		if (hit(wb_adr_i, `SCIS_OFF_XEN))
			rd_mux[5:0] = xen_q;
		if (hit(wb_adr_i, `SCIS_OFF_MODE))
			rd_mux[3:0] = mode_q;
		if (hit(wb_adr_i, `SCIS_OFF_STAT))
			rd_mux[6:0] = {view, ~tx_buf_full_i};
		if (hit(wb_adr_i, `SCIS_OFF_PEND))
			rd_mux[2:0] = {rx_ip_q, tx_ip_q, xs_ip_q};
		if (hit(wb_adr_i, `SCIS_OFF_RXST))
			rd_mux[0] = lock_q;
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
		end
		else
		begin
			ack_q <= req & ~ack_q;
			// read data stands only in the ack cycle
			if (req & ~ack_q & ~wb_we_i)
				dat_q <= rd_mux;
			else
				dat_q <= 32'h00000000;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign rx_fifo_lock_o = lock_q;
	assign rx_keep_null_o = keep_null_q;
	assign rx_hunt_o = hunt_q;
	assign int_req_o = int_q;

endmodule

// ==== tb/scis_top_properties.sv ====
`timescale 1ns/100ps
module scis_chk (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire rx_pop_i,
	input wire rx_pop_special_i,
	input wire rx_bit_valid_i,
	input wire rx_bit_i,
	input wire rx_sync_found_i,
	input wire rx_fifo_lock_o,
	input wire rx_keep_null_o,
	input wire rx_hunt_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_one_end;
		$past(rx_bit_valid_i && rx_bit_i) ##1 !rx_keep_null_o;
	endsequence
	a_ack_after_req: assert property (s_req |=> wb_ack_o)
		else $error("request not answered");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_lock_cause: assert property (
		$rose(rx_fifo_lock_o) |-> $past(rx_pop_i && rx_pop_special_i))
		else $error("lock without special pop");
	a_lock_holds: assert property (
		rx_fifo_lock_o && !wb_ack_o |=> rx_fifo_lock_o)
		else $error("lock dropped without command");
	a_lock_release: assert property (
		$fell(rx_fifo_lock_o) |-> $past(wb_ack_o))
		else $error("lock released outside write");
	a_hunt_clear: assert property (
		rx_sync_found_i && !rx_bit_valid_i && !wb_ack_o |=> !rx_hunt_o)
		else $error("hunt kept after sync");
	a_hunt_cause: assert property (
		$rose(rx_hunt_o) |-> $past(wb_ack_o || rx_bit_valid_i))
		else $error("hunt entered without cause");
	a_null_pulse: assert property (rx_keep_null_o |-> s_one_end)
		else $error("keep null pulse wrong");
endmodule
bind scis_top scis_chk u_chk (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.rx_pop_i(rx_pop_i),
	.rx_pop_special_i(rx_pop_special_i),
	.rx_bit_valid_i(rx_bit_valid_i),
	.rx_bit_i(rx_bit_i),
	.rx_sync_found_i(rx_sync_found_i),
	.rx_fifo_lock_o(rx_fifo_lock_o),
	.rx_keep_null_o(rx_keep_null_o),
	.rx_hunt_o(rx_hunt_o)
);

// ==== tb/scis_dma_model.sv ====
`timescale 1ns/100ps
module scis_dma_model (
	input wire clk_i,
	input wire rst_i,
	input wire lock_i,
	input wire want_i,
	input wire special_i,
	output reg pop_o,
	output reg pop_special_o
);
	// a locked fifo is never drained, as a real dma channel would stall
	always @(posedge clk_i)
	begin
		pop_o <= !rst_i && want_i && !lock_i;
		pop_special_o <= want_i ? special_i : (!rst_i && !pop_special_o);
	end
endmodule

// ==== tb/scis_top_tb_top.sv ====
`timescale 1ns/100ps
`include "scis_consts.vh"
module scis_top_tb_top;
	reg clk_i = 0;
	reg rst_i = 1;
	reg cyc = 0, stb = 0, we = 0, want = 0, spc = 0;
	reg full = 0, bz = 0, cts_n = 1, dcd = 0, sync = 0;
	reg [7:0] adr = 0, dat = 0, e;
	reg [1:0] ei;
	reg [8:0] ev = 0;
	wire [31:0] dat_o;
	wire ack, pop, pops, lock, irq;
	integer mismatches = 0, tests_run = 0, n, i;
	reg [7:0] exq [$];
	reg [1:0] iq [$];
	initial forever #10 clk_i = ~clk_i;
	scis_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i({24'h0, adr}),
		.wb_sel_i(4'h1), .wb_dat_i({24'h0, dat}), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .rx_pop_i(pop), .rx_pop_special_i(pops),
		.rx_char_i(ev[0]), .rx_char_null_i(ev[1]),
		.rx_frame_err_i(ev[2]), .rx_bit_valid_i(ev[3]), .rx_bit_i(ev[4]),
		.rx_sync_found_i(ev[5]), .tx_buf_full_i(full),
		.tx_buf_write_i(ev[6]), .tx_crc_load_i(ev[7]),
		.tx_flag_load_i(ev[8]), .baud_zero_i(bz), .cts_n_i(cts_n),
		.dcd_i(dcd), .sync_i(sync), .rx_fifo_lock_o(lock),
		.rx_keep_null_o(), .rx_hunt_o(), .int_req_o(irq));
	scis_dma_model u_dma (.clk_i(clk_i), .rst_i(rst_i), .lock_i(lock),
		.want_i(want), .special_i(spc), .pop_o(pop), .pop_special_o(pops));
	task conclude;
	begin
		if (mismatches == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	task cw(input integer k);
		repeat (k) @(posedge clk_i);
	endtask
	task bus(input w, input [7:0] a, input [7:0] d);
		integer t;
	begin
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		t = 0;
		@(posedge clk_i);
		while (ack !== 1'b1 && t < 64)
		begin
			@(posedge clk_i);
			t = t + 1;
		end
		if (t == 64)
			mismatches = mismatches + 1;
		cyc <= 1'b0;
		stb <= 1'b0;
	end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		bus(1'b1, a, d);
	endtask
	task chk(input [7:0] a, input [7:0] x);
	begin
		exq.push_back(x);
		iq.push_back(2'h0);
		bus(1'b0, a, 8'h00);
	end
	endtask
	// also notes the interrupt request level expected during the read
	task chki(input [7:0] a, input [7:0] x, input i);
	begin
		exq.push_back(x);
		iq.push_back({1'b1, i});
		bus(1'b0, a, 8'h00);
	end
	endtask
	task pulse(input [8:0] m);
	begin
		@(posedge clk_i);
		ev <= m;
		@(posedge clk_i);
		ev <= 9'h0;
	end
	endtask
	task dma(input s);
	begin
		@(posedge clk_i);
		want <= 1'b1;
		spc <= s;
		@(posedge clk_i);
		want <= 1'b0;
		cw(3);
	end
	endtask
	// expected values are queued by the driver, checked when ack shows
	always @(posedge clk_i)
		if (ack === 1'b1 && we === 1'b0)
		begin
			e = exq.pop_front();
			ei = iq.pop_front();
			tests_run = tests_run + 1;
			if (dat_o !== {24'h0, e})
			begin
				$display("[ERR] t=%0t got %h exp %h", $time, dat_o, e);
				mismatches = mismatches + 1;
			end
			if (ei[1] && irq !== ei[0])
			begin
				$display("[ERR] t=%0t irq %h exp %h", $time, irq, ei[0]);
				mismatches = mismatches + 1;
			end
		end
	initial
	begin
		#1000000;
		mismatches = mismatches + 1;
		conclude;
	end
	initial
	begin
		n = $urandom(65);
		cw(8);
		rst_i <= 1'b0;
		chk(`SCIS_OFF_ICTL, 8'h00);
		chk(`SCIS_OFF_CMD, 8'h00);
		chk(8'h20, 8'h00);
		wr(`SCIS_OFF_ICTL, 8'h18);
		wr(`SCIS_OFF_MICTL, 8'h08);
		for (i = 0; i < 3; i = i + 1)
			dma(1'b0);
		chk(`SCIS_OFF_PEND, 8'h00);
		dma(1'b1);
		chk(`SCIS_OFF_RXST, 8'h01);
		chki(`SCIS_OFF_PEND, 8'h04, 1'b1);
		dma(1'b0);
		chk(`SCIS_OFF_RXST, 8'h01);
		wr(`SCIS_OFF_CMD, 8'h02);
		chk(`SCIS_OFF_RXST, 8'h00);
		chki(`SCIS_OFF_PEND, 8'h00, 1'b0);
		wr(`SCIS_OFF_ICTL, 8'h01);
		cts_n <= 1'b0;
		bz <= 1'b1;
		cw(8);
		chk(`SCIS_OFF_STAT, 8'h29);
		chk(`SCIS_OFF_PEND, 8'h00);
		wr(`SCIS_OFF_XEN, 8'h08);
		wr(`SCIS_OFF_ICTL, 8'h00);
		dcd <= 1'b1;
		cw(8);
		chk(`SCIS_OFF_PEND, 8'h00);
		wr(`SCIS_OFF_CMD, 8'h01);
		wr(`SCIS_OFF_ICTL, 8'h01);
		n = $urandom % 4 + 1;
		for (i = 0; i < n; i = i + 1)
		begin
			dcd <= ~dcd;
			cw(8);
		end
		chk(`SCIS_OFF_PEND, 8'h01);
		wr(`SCIS_OFF_CMD, 8'h01);
		// the first toggle closes; only the later ones count against it
		chk(`SCIS_OFF_PEND, (n % 2 == 0) ? 8'h01 : 8'h00);
		wr(`SCIS_OFF_XEN, 8'h00);
		wr(`SCIS_OFF_CMD, 8'h01);
		chk(`SCIS_OFF_PEND, 8'h00);
		wr(`SCIS_OFF_ICTL, 8'h02);
		chk(`SCIS_OFF_PEND, 8'h00);
		full <= 1'b1;
		cw(2);
		full <= 1'b0;
		cw(2);
		chk(`SCIS_OFF_PEND, 8'h02);
		wr(`SCIS_OFF_CMD, 8'h04);
		chk(`SCIS_OFF_PEND, 8'h00);
		pulse(9'h100);
		chk(`SCIS_OFF_PEND, 8'h02);
		pulse(9'h040);
		chk(`SCIS_OFF_PEND, 8'h00);
		wr(`SCIS_OFF_ICTL, 8'h00);
		full <= 1'b1;
		cw(2);
		full <= 1'b0;
		cw(2);
		chk(`SCIS_OFF_PEND, 8'h00);
		pulse(9'h020);
		wr(`SCIS_OFF_CMD, 8'h20);
		wr(`SCIS_OFF_MODE, 8'h02);
		for (i = 0; i < 8; i = i + 1)
			pulse(9'h018);
		pulse(9'h008);
		wr(`SCIS_OFF_MODE, 8'h01);
		pulse(9'h007);
		pulse(9'h008);
		pulse(9'h018);
		wr(`SCIS_OFF_CMD, 8'h10);
		pulse(9'h080);
		cw(4);
		chk(`SCIS_OFF_STAT, {3'h0, dcd, 4'hd});
		wr(`SCIS_OFF_XEN, 8'h01);
		wr(`SCIS_OFF_ICTL, 8'h01);
		pulse(9'h007);
		chki(`SCIS_OFF_PEND, 8'h01, 1'b1);
		// the break end must be recaptured although latches are closed
		pulse(9'h018);
		chk(`SCIS_OFF_STAT, {3'h0, dcd, 4'hd});
		wr(`SCIS_OFF_XEN, 8'h02);
		wr(`SCIS_OFF_MODE, 8'h00);
		wr(`SCIS_OFF_CMD, 8'h01);
		wr(`SCIS_OFF_CMD, 8'h08);
		chk(`SCIS_OFF_PEND, 8'h00);
		pulse(9'h080);
		chk(`SCIS_OFF_PEND, 8'h01);
		wr(`SCIS_OFF_XEN, 8'h10);
		wr(`SCIS_OFF_CMD, 8'h01);
		pulse(9'h020);
		chk(`SCIS_OFF_PEND, 8'h01);
		wr(`SCIS_OFF_CMD, 8'h01);
		wr(`SCIS_OFF_CMD, 8'h20);
		chk(`SCIS_OFF_PEND, 8'h01);
		wr(`SCIS_OFF_XEN, 8'h20);
		wr(`SCIS_OFF_CMD, 8'h01);
		bz <= 1'b0;
		cw(2);
		chk(`SCIS_OFF_PEND, 8'h00);
		bz <= 1'b1;
		cw(2);
		chk(`SCIS_OFF_PEND, 8'h01);
		bz <= 1'b0;
		cw(2);
		chk(`SCIS_OFF_STAT, {2'h0, 1'h1, dcd, 4'hd});
		wr(`SCIS_OFF_MODE, 8'h09);
		wr(`SCIS_OFF_XEN, 8'h10);
		wr(`SCIS_OFF_CMD, 8'h01);
		sync <= 1'b1;
		cw(8);
		chk(`SCIS_OFF_PEND, 8'h00);
		wr(`SCIS_OFF_MODE, 8'h01);
		chki(`SCIS_OFF_PEND, 8'h01, 1'b1);
		conclude;
	end
endmodule
